/* src/defp_regs.svh */
// register offsets, field positions, reset values and timing figures
`ifndef DEFP_REGS_SVH
`define DEFP_REGS_SVH
`define DEFP_CTRL_OFS 8'h00
`define DEFP_ITHR_OFS 8'h04
`define DEFP_UTHR_OFS 8'h08
`define DEFP_ANGA_OFS 8'h0C
`define DEFP_ANGB_OFS 8'h10
`define DEFP_STAT_OFS 8'h14
`define DEFP_PREF_OFS 8'h18
`define DEFP_EVNT_OFS 8'h1C
`define DEFP_CTRL_RST 32'h1111_1101
`define DEFP_ITHR_RST 32'h0000_04B0
`define DEFP_UTHR_RST 32'h0000_07D0
`define DEFP_ANGA_RST 32'h01C2_0370
`define DEFP_ANGB_RST 32'h1C7C_0000
`define DEFP_MODE_LSB 0
`define DEFP_FORCE_LSB 4
`define DEFP_POL_LSB 8
`define DEFP_ISRC_LSB 12
`define DEFP_MAG_LSB 16
`define DEFP_USRC_LSB 20
`define DEFP_GND_LSB 24
`define DEFP_MCD_LSB 28
`define DEFP_HI_LSB 16
`define DEFP_I_NOM 1000
`define DEFP_U_NOM 10000
`define DEFP_SQUELCH_DIV 100
`define DEFP_RESET_PCT 97
`define DEFP_ANG_FULL 3600
`define DEFP_ANG_HALF 1800
`define DEFP_ANG_QUART 900
`define DEFP_UNE_CENTRE 2700
`define DEFP_PF_WIN_MS 20
`define DEFP_STAMP_MS 1
`define DEFP_CLK_KHZ 125000
`define DEFP_PF_SHIFT 4
`endif

/* src/defp_pkg.sv */
// types shared by the directional earth-fault pick-up block
package defp_pkg;
    typedef enum logic [2:0] {
        DEFP_LN_ON = 3'h1,
        DEFP_LN_BLK = 3'h2,
        DEFP_LN_TEST = 3'h3,
        DEFP_LN_TBLK = 3'h4,
        DEFP_LN_OFF = 3'h5
    } defp_logical_node_mode_t;
    typedef enum logic [2:0] {
        DEFP_GND_UNE = 3'h1,
        DEFP_GND_COMP = 3'h2,
        DEFP_GND_DIRECT = 3'h3,
        DEFP_GND_BROAD = 3'h4
    } defp_gnd_t;
    typedef enum logic [1:0] {
        DEFP_COND_NORMAL = 2'h0,
        DEFP_COND_START = 2'h1,
        DEFP_COND_TRIP = 2'h2,
        DEFP_COND_BLOCKED = 2'h3
    } defp_cond_t;
    typedef struct packed {
        logic [15:0] coarse_rms;
        logic [15:0] coarse_true_rms;
        logic [15:0] coarse_pp;
        logic [15:0] sens_rms;
        logic [15:0] sens_true_rms;
        logic [15:0] sens_pp;
        logic [15:0] calc_rms;
        logic [11:0] coarse_ang;
        logic [11:0] sens_ang;
        logic [11:0] calc_ang;
    } defp_cur_t;
    typedef struct packed {
        logic [15:0] calc_mag;
        logic [15:0] third_mag;
        logic [15:0] fourth_mag;
        logic [11:0] calc_ang;
        logic [11:0] third_ang;
        logic [11:0] fourth_ang;
    } defp_volt_t;
endpackage : defp_pkg

/* src/defp_top.sv */
// directional earth-fault pick-up logic with apb register access
`timescale 1ns/1ps
`include "defp_regs.svh"
module defp_top import defp_pkg::*; #(
    parameter int PF_WIN_CYC = `DEFP_PF_WIN_MS * `DEFP_CLK_KHZ,
    parameter int STAMP_CYC = `DEFP_STAMP_MS * `DEFP_CLK_KHZ
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // measurement channels
    input wire defp_cur_t residual_current,
    input wire defp_volt_t neutral_voltage,
    input wire logic meas_line_neutral,
    input wire logic multi_criteria_detect,
    // global controls
    input wire logic block_in,
    input wire logic logical_node_mode_allow,
    input wire logic force_allow,
    // function outputs
    output logic start,
    output logic trip,
    output logic blocked,
    output logic [1:0] condition
);
    localparam int PF_TICK_CYC = PF_WIN_CYC >> `DEFP_PF_SHIFT;

    function automatic logic [11:0] wrap_ang(input logic signed [13:0] a);
        logic signed [13:0] r;
        r = a;
        if (r < 0) begin
            r = r + 14'(`DEFP_ANG_FULL);
        end else if (r >= 14'(`DEFP_ANG_FULL)) begin
            r = r - 14'(`DEFP_ANG_FULL);
        end
        return r[11:0];
    endfunction : wrap_ang

    function automatic logic signed [12:0] rel_ang(input logic [11:0] a, input logic [11:0] c);
        logic [11:0] w;
        w = wrap_ang($signed({2'b00, a}) - $signed({2'b00, c}));
        if (w >= 12'(`DEFP_ANG_HALF)) begin
            return $signed({1'b0, w}) - 13'sd3600;
        end
        return $signed({1'b0, w});
    endfunction : rel_ang

    logic [31:0] ctrl_q, ithr_q, uthr_q, anga_q, angb_q;
    logic [31:0] prdata_q, evnt_q;
    logic pready_q, pslverr_q;
    logic pick_q, start_q, trip_q, blocked_q;
    logic ang_valid;
    logic [1:0] cond_q;
    logic fault_comp_q;
    logic [15:0] pf_avg_last_q, pf_avg_prev_q, pf_hold_q;
    logic [19:0] pf_sum_q;
    logic [31:0] pf_tick_q;
    logic [`DEFP_PF_SHIFT-1:0] pf_cnt_q;
    logic [31:0] ms_div_q;
    logic [23:0] ms_cnt_q;

    // settings fields
    logic [2:0] set_mode, set_force, set_gnd;
    logic [1:0] set_pol, set_isrc, set_mag, set_usrc, set_mcd;
    assign set_mode = ctrl_q[`DEFP_MODE_LSB +: 3];
    assign set_force = ctrl_q[`DEFP_FORCE_LSB +: 3];
    assign set_pol = ctrl_q[`DEFP_POL_LSB +: 2];
    assign set_isrc = ctrl_q[`DEFP_ISRC_LSB +: 2];
    assign set_mag = ctrl_q[`DEFP_MAG_LSB +: 2];
    assign set_usrc = ctrl_q[`DEFP_USRC_LSB +: 3] == 3'h4 ? 2'h3 : ctrl_q[`DEFP_USRC_LSB +: 2];
    assign set_gnd = ctrl_q[`DEFP_GND_LSB +: 3];
    assign set_mcd = ctrl_q[`DEFP_MCD_LSB +: 2];

    // apb access
    logic apb_acc, apb_wr;
    assign apb_acc = psel && penable && pready_q;
    assign apb_wr = apb_acc && pwrite;

    function automatic logic addr_ok(input logic [7:0] a);
        return a <= `DEFP_EVNT_OFS && a[1:0] == 2'b00;
    endfunction : addr_ok

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= psel && !penable && !pready_q;
            pslverr_q <= psel && !penable && !pready_q && !addr_ok(paddr);
        end
    end

    // static settings, written only by software, never by setting groups
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `DEFP_CTRL_RST;
            ithr_q <= `DEFP_ITHR_RST;
            uthr_q <= `DEFP_UTHR_RST;
            anga_q <= `DEFP_ANGA_RST;
            angb_q <= `DEFP_ANGB_RST;
        end else if (apb_wr) begin
            case (paddr)
                `DEFP_CTRL_OFS: ctrl_q <= pwdata & 32'h3773_3377;
                `DEFP_ITHR_OFS: ithr_q <= {16'h0000, pwdata[15:0]};
                `DEFP_UTHR_OFS: uthr_q <= {16'h0000, pwdata[15:0]};
                `DEFP_ANGA_OFS: anga_q <= {4'h0, pwdata[27:16], 4'h0, pwdata[11:0]};
                `DEFP_ANGB_OFS: angb_q <= {3'h0, pwdata[28:16], 4'h0, pwdata[11:0]};
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pready_q) begin
            case (paddr)
                `DEFP_CTRL_OFS: prdata_q <= ctrl_q;
                `DEFP_ITHR_OFS: prdata_q <= ithr_q;
                `DEFP_UTHR_OFS: prdata_q <= uthr_q;
                `DEFP_ANGA_OFS: prdata_q <= anga_q;
                `DEFP_ANGB_OFS: prdata_q <= angb_q;
                `DEFP_STAT_OFS: prdata_q <= {24'h00_0000, ang_valid, fault_comp_q, pick_q,
                    blocked_q, trip_q, start_q, cond_q};
                `DEFP_PREF_OFS: prdata_q <= {16'h0000, pf_hold_q};
                `DEFP_EVNT_OFS: prdata_q <= evnt_q;
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // current source and magnitude selection
    logic [15:0] cur_mag, volt_mag;
    logic [11:0] cur_ang, volt_ang;
    always_comb begin
        cur_ang = residual_current.coarse_ang;
        case (set_isrc)
            2'h2: begin
                cur_ang = residual_current.sens_ang;
                case (set_mag)
                    2'h2: cur_mag = residual_current.sens_true_rms;
                    2'h3: cur_mag = residual_current.sens_pp;
                    default: cur_mag = residual_current.sens_rms;
                endcase
            end
            2'h3: begin
                cur_ang = residual_current.calc_ang;
                cur_mag = residual_current.calc_rms;
            end
            default: begin
                case (set_mag)
                    2'h2: cur_mag = residual_current.coarse_true_rms;
                    2'h3: cur_mag = residual_current.coarse_pp;
                    default: cur_mag = residual_current.coarse_rms;
                endcase
            end
        endcase
    end

    always_comb begin
        case (set_usrc)
            2'h2: begin
                volt_mag = neutral_voltage.calc_mag;
                volt_ang = neutral_voltage.calc_ang;
            end
            2'h3: begin
                if (ctrl_q[`DEFP_USRC_LSB +: 3] == 3'h4) begin
                    volt_mag = neutral_voltage.fourth_mag;
                    volt_ang = neutral_voltage.fourth_ang;
                end else begin
                    volt_mag = neutral_voltage.third_mag;
                    volt_ang = neutral_voltage.third_ang;
                end
            end
            default: begin
                volt_mag = meas_line_neutral ? neutral_voltage.calc_mag : neutral_voltage.third_mag;
                volt_ang = meas_line_neutral ? neutral_voltage.calc_ang : neutral_voltage.third_ang;
            end
        endcase
    end

    // squelch, fault angle and direction regions
    logic ang_ok, is_comp, cur_over, cur_under, volt_over;
    logic [11:0] fault_ang;
    logic signed [12:0] rel_comp, rel_dir;
    logic signed [12:0] border, blinder;
    assign ang_valid = cur_mag > 16'(`DEFP_I_NOM / `DEFP_SQUELCH_DIV)
        && volt_mag > 16'(`DEFP_U_NOM / `DEFP_SQUELCH_DIV);
    assign fault_ang = wrap_ang($signed({2'b00, cur_ang}) - $signed({2'b00, volt_ang})
        + (set_pol == 2'h2 ? 14'sd1800 : 14'sd0));
    assign rel_comp = rel_ang(fault_ang, 12'(`DEFP_ANG_HALF));
    assign rel_dir = rel_ang(fault_ang, angb_q[11:0]);
    assign border = $signed({anga_q[27], anga_q[27:16]});
    assign blinder = $signed(angb_q[28:16]);

    always_comb begin
        is_comp = 1'b0;
        case (defp_gnd_t'(set_gnd))
            DEFP_GND_COMP: begin
                is_comp = 1'b1;
                ang_ok = rel_comp >= blinder && rel_comp <= 13'sd900;
            end
            DEFP_GND_DIRECT: begin
                ang_ok = (rel_dir < 0 ? -rel_dir : rel_dir) <= $signed({1'b0, anga_q[11:0]});
            end
            DEFP_GND_BROAD: begin
                is_comp = rel_comp > -13'sd900 && rel_comp <= border;
                ang_ok = (is_comp && (set_mcd != 2'h2 || multi_criteria_detect))
                    || (rel_comp > border);
            end
            default: begin
                ang_ok = rel_ang(fault_ang, 12'(`DEFP_UNE_CENTRE)) > -13'sd900
                    && rel_ang(fault_ang, 12'(`DEFP_UNE_CENTRE)) < 13'sd900;
            end
        endcase
    end

    assign cur_over = cur_mag > ithr_q[15:0];
    assign cur_under = 23'(cur_mag) * 23'd100 < 23'(ithr_q[15:0]) * 23'(`DEFP_RESET_PCT);
    assign volt_over = volt_mag > uthr_q[15:0];

    // pick-up with hysteresis
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pick_q <= 1'b0;
            fault_comp_q <= 1'b0;
        end else if (!pick_q) begin
            pick_q <= cur_over && volt_over && ang_valid && ang_ok;
            fault_comp_q <= is_comp;
        end else if (cur_under || !volt_over || !ang_valid || !ang_ok) begin
            pick_q <= 1'b0;
        end
    end

    // mode, force and outputs
    defp_logical_node_mode_t mode_eff;
    logic blk_now, start_now, force_on;
    logic trip_now, blk_out;
    assign mode_eff = logical_node_mode_allow ? defp_logical_node_mode_t'(set_mode) : DEFP_LN_ON;
    assign force_on = force_allow && set_force != 3'h0;
    assign blk_now = force_on ? set_force == 3'h3
        : (block_in || mode_eff == DEFP_LN_BLK || mode_eff == DEFP_LN_TBLK);
    assign start_now = force_on ? (set_force != 3'h3)
        : (pick_q && !blk_now && mode_eff != DEFP_LN_OFF);
    assign trip_now = force_on ? set_force inside {3'h2, 3'h5, 3'h7} : start_now;
    assign blk_out = blk_now && mode_eff != DEFP_LN_OFF;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_q <= 1'b0;
            trip_q <= 1'b0;
            blocked_q <= 1'b0;
            cond_q <= DEFP_COND_NORMAL;
        end else begin
            start_q <= start_now;
            trip_q <= trip_now;
            blocked_q <= blk_out;
            if (blk_out) begin
                cond_q <= DEFP_COND_BLOCKED;
            end else if (trip_now) begin
                cond_q <= DEFP_COND_TRIP;
            end else if (start_now) begin
                cond_q <= DEFP_COND_START;
            end else begin
                cond_q <= DEFP_COND_NORMAL;
            end
        end
    end

    // millisecond stamp and transition record
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_div_q <= 32'h0000_0000;
            ms_cnt_q <= 24'h00_0000;
        end else if (ms_div_q == 32'(STAMP_CYC - 1)) begin
            ms_div_q <= 32'h0000_0000;
            ms_cnt_q <= ms_cnt_q + 24'h00_0001;
        end else begin
            ms_div_q <= ms_div_q + 32'h0000_0001;
        end
    end

    logic [1:0] out_chg;
    assign out_chg = {blocked_q, start_q} ^ {blk_out, start_now};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evnt_q <= 32'h0000_0000;
        end else if (|out_chg) begin
            evnt_q <= {4'h0, blk_out, start_now, out_chg, ms_cnt_q};
        end
    end

    // pre-fault averaging over fixed windows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pf_tick_q <= 32'h0000_0000;
            pf_cnt_q <= '0;
            pf_sum_q <= 20'h0_0000;
            pf_avg_last_q <= 16'h0000;
            pf_avg_prev_q <= 16'h0000;
        end else if (pf_tick_q == 32'(PF_TICK_CYC - 1)) begin
            pf_tick_q <= 32'h0000_0000;
            pf_cnt_q <= pf_cnt_q + {{(`DEFP_PF_SHIFT - 1){1'b0}}, 1'b1};
            if (&pf_cnt_q) begin
                pf_sum_q <= 20'h0_0000;
                pf_avg_last_q <= 16'((pf_sum_q + 20'(cur_mag)) >> `DEFP_PF_SHIFT);
                pf_avg_prev_q <= pf_avg_last_q;
            end else begin
                pf_sum_q <= pf_sum_q + 20'(cur_mag);
            end
        end else begin
            pf_tick_q <= pf_tick_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pf_hold_q <= 16'h0000;
        end else if (start_now && !start_q) begin
            pf_hold_q <= pf_avg_prev_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign start = start_q;
    assign trip = trip_q;
    assign blocked = blocked_q;
    assign condition = cond_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    squelch_gate_a: assert property (!ang_valid && !pick_q |=> !pick_q)
        else $error("pick-up without valid angle");
    pickup_all_a: assert property ($rose(pick_q) |-> $past(cur_over && volt_over && ang_ok))
        else $error("pick-up without all conditions");
    release_hyst_a: assert property (pick_q && !cur_under && volt_over && ang_valid && ang_ok
        |=> pick_q)
        else $error("early release");
    start_block_a: assert property (!force_on && blk_now |=> !start_q)
        else $error("start while blocked");
    start_pick_a: assert property (!force_on && !pick_q |=> !start_q)
        else $error("start without pick-up");
    cond_block_a: assert property (blocked_q |-> cond_q == DEFP_COND_BLOCKED)
        else $error("condition not blocked");
    mode_off_a: assert property (!force_on && mode_eff == DEFP_LN_OFF |=> !start_q && !blocked_q)
        else $error("off mode output");
    ready_one_a: assert property (psel && !penable |=> pready_q ##1 !pready_q)
        else $error("apb answer timing");
    force_trip_a: assert property (force_allow && set_force inside {3'h2, 3'h5, 3'h7}
        |=> trip_q && start_q)
        else $error("forced trip missing");
    cover_pick_c: cover property ($rose(pick_q));
    cover_block_c: cover property (pick_q && blk_now);
    cover_broad_c: cover property (set_gnd == 3'h4 && is_comp && pick_q);
endmodule : defp_top

/* bench/defp_meas_model.sv */
// measurement channel model: one live current and one live voltage channel
`timescale 1ns/1ps
module defp_meas_model import defp_pkg::*; (
    // channel choice
    input wire logic [2:0] ch,
    input wire logic [1:0] vch,
    // live values
    input wire logic [15:0] mag,
    input wire logic [11:0] ang,
    input wire logic [15:0] vmag,
    input wire logic [11:0] vang,
    // channels toward the block
    output defp_cur_t cur,
    output defp_volt_t volt
);
    // unselected magnitude channels read zero, so a wrong source choice loses squelch
    always_comb begin
        cur = '0;
        volt = '0;
        cur.coarse_ang = ang;
        cur.sens_ang = ang;
        cur.calc_ang = ang;
        volt.calc_ang = vang;
        volt.third_ang = vang;
        volt.fourth_ang = vang;
        case (ch)
            3'h0: cur.coarse_rms = mag;
            3'h1: cur.coarse_true_rms = mag;
            3'h2: cur.coarse_pp = mag;
            3'h3: cur.sens_rms = mag;
            3'h4: cur.sens_true_rms = mag;
            3'h5: cur.sens_pp = mag;
            default: cur.calc_rms = mag;
        endcase
        case (vch)
            2'h0: volt.calc_mag = vmag;
            2'h1: volt.third_mag = vmag;
            default: volt.fourth_mag = vmag;
        endcase
    end
endmodule : defp_meas_model

/* bench/testbench.sv */
// self-checking bench for the directional earth-fault pick-up block
`timescale 1ns/1ps
`include "defp_regs.svh"
module testbench import defp_pkg::*; ;
    // clock, reset and apb
    logic pclk = 1'b0, presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, c;
    logic pready, pslverr, er;
    // model controls and global inputs
    logic [2:0] ch = 3'h0;
    logic [1:0] vch = 2'h0;
    logic [15:0] mag = 16'h0, vmag = 16'h0;
    logic [11:0] ang = 12'h0, vang = 12'h0;
    logic mln = 1'b1, mcd_in = 1'b0, blk = 1'b0, ln_allow = 1'b1, f_allow = 1'b0;
    defp_cur_t cur;
    defp_volt_t volt;
    logic start, trip, blocked;
    logic [1:0] condition;
    int error_cnt = 0, num_checks = 0, v;
    logic [63:0] fexp = 64'h1A11_1A11_071A_1100;

    always #4 pclk = ~pclk;

    defp_top #(.PF_WIN_CYC(160), .STAMP_CYC(10)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .residual_current(cur),
        .neutral_voltage(volt), .meas_line_neutral(mln),
        .multi_criteria_detect(mcd_in), .block_in(blk), .logical_node_mode_allow(ln_allow),
        .force_allow(f_allow), .start(start), .trip(trip), .blocked(blocked),
        .condition(condition)
    );
    defp_meas_model mdl (
        .ch(ch), .vch(vch), .mag(mag), .ang(ang), .vmag(vmag), .vang(vang),
        .cur(cur), .volt(volt)
    );

    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task chk_outs(input logic [4:0] exp);
        chk_word({27'h0, start, trip, blocked, condition}, {27'h0, exp});
    endtask : chk_outs

    // one apb transfer, entered and left just after a rising edge
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (n >= 50) error_cnt++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    function automatic logic [31:0] ctrl(input int md, fc, pl, is, mg, us, gd, mc);
        return 32'((md << `DEFP_MODE_LSB) | (fc << `DEFP_FORCE_LSB) | (pl << `DEFP_POL_LSB)
            | (is << `DEFP_ISRC_LSB) | (mg << `DEFP_MAG_LSB) | (us << `DEFP_USRC_LSB)
            | (gd << `DEFP_GND_LSB) | (mc << `DEFP_MCD_LSB));
    endfunction : ctrl

    function automatic logic [31:0] gs(input int gd, pl);
        return ctrl(1, 0, pl, 1, 1, 2, gd, 1);
    endfunction : gs

    // settings, live values, then outputs three edges later
    task run(input logic [31:0] cv, input int h, m, vm, a, va, input logic [4:0] e);
        apb(`DEFP_CTRL_OFS, 1'b1, cv);
        ch <= 3'(h);
        mag <= 16'(m);
        vmag <= 16'(vm);
        ang <= 12'(a);
        vang <= 12'(va);
        repeat (3) @(posedge pclk);
        chk_outs(e);
    endtask : run

    initial begin
        repeat (30000) @(posedge pclk);
        error_cnt++;
        $display("watchdog expired");
        stop_test();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(`DEFP_CTRL_OFS, 1'b0, 32'h0);
        chk_word(rd, `DEFP_CTRL_RST);
        apb(`DEFP_ANGA_OFS, 1'b0, 32'h0);
        chk_word(rd, `DEFP_ANGA_RST);
        apb(`DEFP_ANGB_OFS, 1'b0, 32'h0);
        chk_word(rd, `DEFP_ANGB_RST);
        apb(8'h05, 1'b1, 32'h1);
        chk_word({31'h0, er}, 32'h1);
        apb(8'h20, 1'b0, 32'h0);
        chk_word(rd, 32'h0);
        apb(`DEFP_ITHR_OFS, 1'b0, 32'h0);
        chk_word(rd, `DEFP_ITHR_RST);
        apb(`DEFP_ITHR_OFS, 1'b1, 32'h64);
        apb(`DEFP_UTHR_OFS, 1'b1, 32'h1F4);
        $display("test registers done");
        for (int i = 0; i < 7; i++) begin
            c = ctrl(1, 0, 1, i / 3 + 1, (i + i / 6) % 3 + 1, 2, 1, 1);
            run(c, i, 200, 1000, 2700, 0, 5'h1A);
            run(c, (i + 1) % 7, 200, 1000, 2700, 0, 5'h00);
        end
        for (int j = 0; j < 5; j++) begin
            v = j == 4 ? 1 : (j < 2 ? 0 : j - 1);
            mln <= (j != 4);
            vch <= 2'(v);
            run(ctrl(1, 0, 1, 1, 1, j % 4 + 1, 1, 1), 0, 200, 1000, 2700, 0, 5'h1A);
            vch <= 2'((v + 1) % 3);
            run(ctrl(1, 0, 1, 1, 1, j % 4 + 1, 1, 1), 0, 200, 1000, 2700, 0, 5'h00);
        end
        mln <= 1'b1;
        vch <= 2'h0;
        $display("test sources done");
        apb(`DEFP_ITHR_OFS, 1'b1, 32'h5);
        apb(`DEFP_UTHR_OFS, 1'b1, 32'h32);
        run(gs(1, 1), 0, 10, 1000, 2700, 0, 5'h00);
        run(gs(1, 1), 0, 11, 1000, 2700, 0, 5'h1A);
        run(gs(1, 1), 0, 200, 100, 2700, 0, 5'h00);
        run(gs(1, 1), 0, 200, 101, 2700, 0, 5'h1A);
        apb(`DEFP_ITHR_OFS, 1'b1, 32'h3E8);
        run(gs(1, 1), 0, 1000, 1000, 2700, 0, 5'h00);
        run(gs(1, 1), 0, 1001, 1000, 2700, 0, 5'h1A);
        run(gs(1, 1), 0, 971, 1000, 2700, 0, 5'h1A);
        run(gs(1, 1), 0, 969, 1000, 2700, 0, 5'h00);
        run(gs(1, 1), 0, 971, 1000, 2700, 0, 5'h00);
        $display("test levels done");
        apb(`DEFP_ITHR_OFS, 1'b1, 32'h64);
        run(gs(1, 1), 0, 200, 1000, 900, 0, 5'h00);
        run(gs(1, 1), 0, 200, 1000, 0, 900, 5'h1A);
        run(gs(1, 2), 0, 200, 1000, 900, 0, 5'h1A);
        run(gs(2, 1), 0, 200, 1000, 1800, 0, 5'h1A);
        run(gs(2, 1), 0, 200, 1000, 0, 0, 5'h00);
        apb(`DEFP_ANGB_OFS, 1'b1, 32'h0);
        run(gs(2, 1), 0, 200, 1000, 1350, 0, 5'h00);
        run(gs(2, 1), 0, 200, 1000, 2250, 0, 5'h1A);
        run(gs(3, 1), 0, 200, 1000, 870, 0, 5'h1A);
        run(gs(3, 1), 0, 200, 1000, 890, 0, 5'h00);
        apb(`DEFP_ANGB_OFS, 1'b1, `DEFP_ANGB_RST | 32'h708);
        run(gs(3, 1), 0, 200, 1000, 1800, 0, 5'h1A);
        run(gs(3, 1), 0, 200, 1000, 0, 0, 5'h00);
        apb(`DEFP_ANGB_OFS, 1'b1, `DEFP_ANGB_RST);
        run(gs(4, 1), 0, 200, 1000, 2200, 0, 5'h1A);
        apb(`DEFP_STAT_OFS, 1'b0, 32'h0);
        chk_word({31'h0, rd[6]}, 32'h1);
        run(gs(4, 1), 0, 0, 1000, 2300, 0, 5'h00);
        run(gs(4, 1), 0, 200, 1000, 2300, 0, 5'h1A);
        apb(`DEFP_STAT_OFS, 1'b0, 32'h0);
        chk_word({31'h0, rd[6]}, 32'h0);
        run(ctrl(1, 0, 1, 1, 1, 2, 4, 2), 0, 200, 1000, 1800, 0, 5'h00);
        mcd_in <= 1'b1;
        run(ctrl(1, 0, 1, 1, 1, 2, 4, 2), 0, 200, 1000, 1800, 0, 5'h1A);
        mcd_in <= 1'b0;
        run(ctrl(1, 0, 1, 1, 1, 2, 1, 2), 0, 200, 1000, 2700, 0, 5'h1A);
        $display("test angles done");
        blk <= 1'b1;
        run(gs(1, 1), 0, 200, 1000, 2700, 0, 5'h07);
        blk <= 1'b0;
        run(ctrl(5, 0, 1, 1, 1, 2, 1, 1), 0, 200, 1000, 2700, 0, 5'h00);
        run(ctrl(2, 0, 1, 1, 1, 2, 1, 1), 0, 200, 1000, 2700, 0, 5'h07);
        run(ctrl(3, 0, 1, 1, 1, 2, 1, 1), 0, 200, 1000, 2700, 0, 5'h1A);
        ln_allow <= 1'b0;
        run(ctrl(5, 0, 1, 1, 1, 2, 1, 1), 0, 200, 1000, 2700, 0, 5'h1A);
        ln_allow <= 1'b1;
        mag <= 16'h0;
        f_allow <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            apb(`DEFP_CTRL_OFS, 1'b1, ctrl(1, k, 1, 1, 1, 2, 1, 1));
            @(posedge pclk);
            chk_outs(fexp[k * 8 +: 5]);
        end
        f_allow <= 1'b0;
        apb(`DEFP_CTRL_OFS, 1'b1, ctrl(1, 3, 1, 1, 1, 2, 1, 1));
        @(posedge pclk);
        chk_word({30'h0, condition}, 32'h0);
        $display("test modes done");
        apb(`DEFP_ITHR_OFS, 1'b1, 32'h3E8);
        run(gs(1, 1), 0, 500, 1000, 2700, 0, 5'h00);
        repeat (500) @(posedge pclk);
        apb(`DEFP_ITHR_OFS, 1'b1, 32'h190);
        repeat (2) @(posedge pclk);
        chk_outs(5'h1A);
        apb(`DEFP_PREF_OFS, 1'b0, 32'h0);
        chk_word(rd, 32'h1F4);
        apb(`DEFP_STAT_OFS, 1'b0, 32'h0);
        chk_word({26'h0, rd[5:0]}, 32'h2E);
        apb(`DEFP_EVNT_OFS, 1'b0, 32'h0);
        chk_word({28'h0, rd[27:24]}, 32'h5);
        $display("test prefault done");
        stop_test();
    end
endmodule : testbench
